// ---- pwp_pkg.sv ----
// Constants for the peripheral write-protect bank of the third bridge
package pwp_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register offsets
  localparam logic [7:0] OFF_PROTECT_CLEAR = 8'h00;
  localparam logic [7:0] OFF_PROTECT_SET   = 8'h04;

  // Value of the bank after reset
  localparam logic [31:0] GUARD_RESET = 32'h0080_0000;

  // Bit positions of the guarded peripherals
  localparam int unsigned POS_EVENT_ROUTER   = 1;
  localparam int unsigned POS_SERIAL_LO      = 2;
  localparam int unsigned POS_SERIAL_HI      = 7;
  localparam int unsigned POS_TIMER_LO       = 8;
  localparam int unsigned POS_TIMER_HI       = 15;
  localparam int unsigned POS_ADC            = 16;
  localparam int unsigned POS_ANALOG_COMP    = 17;
  localparam int unsigned POS_DAC            = 18;
  localparam int unsigned POS_TOUCH_SENSE    = 19;

  // Bits that software may change
  localparam logic [31:0] GUARD_WRITABLE = 32'h000F_FFFE;
endpackage

// ---- pwp_cell.sv ----
// One write-protect flag with set and clear strobes
`timescale 1ns/1ps
`default_nettype none
module pwp_cell #(
  parameter logic RST_VAL  = 1'b0,
  parameter logic WRITABLE = 1'b1
) (
  input  wire logic clk,     // Bus clock
  input  wire logic rst_n,   // Synchronous reset, active low
  input  wire logic ce,      // Clock enable
  input  wire logic set_req, // Write of one to the set register
  input  wire logic clr_req, // Write of one to the clear register
  output var  logic q        // Current protection state
);
  logic next_q;

  always_comb begin
    next_q = q;
    if (WRITABLE && set_req) begin
      next_q = 1'b1;
    end else if (WRITABLE && clr_req) begin
      next_q = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= RST_VAL;
    end else if (ce) begin
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

// ---- pwp_bank.sv ----
// Write-protect register bank for the peripherals of the third bridge
`timescale 1ns/1ps
`default_nettype none
module pwp_bank (
  input  wire logic        clk,       // Bus clock, 100 MHz
  input  wire logic        rst_n,     // Synchronous reset, active low
  input  wire logic        ce,        // Clock enable, freezes all state
  input  wire logic [7:0]  reg_addr,  // Byte offset of the access
  input  wire logic        reg_wr,    // Write strobe
  input  wire logic        reg_rd,    // Read strobe
  input  wire logic [31:0] reg_wdata, // Write data
  output var  logic [31:0] reg_rdata, // Read data, valid after read
  output var  logic        reg_err,   // Access to unmapped offset
  output var  logic [31:0] guard      // Protection state per peripheral
);
  ////////////////////////////////////////////////////////////////////////
  // Address decode
  logic        hit_set;
  logic        hit_clr;
  logic [31:0] set_bits;
  logic [31:0] clr_bits;

  always_comb begin
    hit_set = 1'b0;
    hit_clr = 1'b0;
    if (reg_addr == pwp_pkg::OFF_PROTECT_SET) begin
      hit_set = 1'b1;
    end else if (reg_addr == pwp_pkg::OFF_PROTECT_CLEAR) begin
      hit_clr = 1'b1;
    end
  end

  // Zeros written select nothing
  assign set_bits = (reg_wr && hit_set) ? reg_wdata : 32'h0000_0000;
  assign clr_bits = (reg_wr && hit_clr) ? reg_wdata : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // Protection flags, one per bit position
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_bit
      pwp_cell #(
        .RST_VAL  (pwp_pkg::GUARD_RESET[gi]),
        .WRITABLE (pwp_pkg::GUARD_WRITABLE[gi])
      ) u_cell (
        .clk     (clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .set_req (set_bits[gi]),
        .clr_req (clr_bits[gi]),
        .q       (guard[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Read path
  logic [31:0] next_rdata;
  logic        next_err;

  always_comb begin
    next_rdata = reg_rdata;
    next_err   = reg_err;
    if (reg_rd || reg_wr) begin
      next_err   = !(hit_set || hit_clr);
      next_rdata = 32'h0000_0000;
      if (reg_rd && (hit_set || hit_clr)) begin
        next_rdata = guard;
      end
    end else begin
      next_err = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
      reg_err   <= 1'b0;
    end else if (ce) begin
      reg_rdata <= next_rdata;
      reg_err   <= next_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  localparam int unsigned SER_LO = pwp_pkg::POS_SERIAL_LO;
  localparam int unsigned SER_HI = pwp_pkg::POS_SERIAL_HI;
  localparam int unsigned TMR_LO = pwp_pkg::POS_TIMER_LO;
  localparam int unsigned TMR_HI = pwp_pkg::POS_TIMER_HI;
  localparam int unsigned ANA_LO = pwp_pkg::POS_ADC;
  localparam int unsigned ANA_HI = pwp_pkg::POS_TOUCH_SENSE;

  property p_set_zero_keeps;
    @(posedge clk) disable iff (!rst_n)
      (ce && reg_wr && reg_addr == pwp_pkg::OFF_PROTECT_SET)
      |=> ((guard & ~$past(reg_wdata)) == ($past(guard) & ~$past(reg_wdata)));
  endproperty
  a_set_zero_keeps: assert property (p_set_zero_keeps)
    else $error("set write with zero changed a protection bit");

  property p_set_one_protects;
    @(posedge clk) disable iff (!rst_n)
      (ce && reg_wr && reg_addr == pwp_pkg::OFF_PROTECT_SET)
      |=> ((guard & $past(reg_wdata) & pwp_pkg::GUARD_WRITABLE)
           == ($past(reg_wdata) & pwp_pkg::GUARD_WRITABLE));
  endproperty
  a_set_one_protects: assert property (p_set_one_protects)
    else $error("set write with one did not protect");

  property p_serial_readback;
    @(posedge clk) disable iff (!rst_n)
      (ce && reg_rd && reg_addr == pwp_pkg::OFF_PROTECT_SET)
      |=> (reg_rdata[7:2] == $past(guard[7:2]));
  endproperty
  a_serial_readback: assert property (p_serial_readback)
    else $error("serial unit bits read back wrong");

  property p_timer_readback;
    @(posedge clk) disable iff (!rst_n)
      (ce && reg_rd && reg_addr == pwp_pkg::OFF_PROTECT_CLEAR)
      |=> (reg_rdata[15:8] == $past(guard[15:8]));
  endproperty
  a_timer_readback: assert property (p_timer_readback)
    else $error("timer bits read back wrong");

  property p_fixed_bits;
    @(posedge clk) disable iff (!rst_n)
      ((guard & ~pwp_pkg::GUARD_WRITABLE)
       == (pwp_pkg::GUARD_RESET & ~pwp_pkg::GUARD_WRITABLE));
  endproperty
  a_fixed_bits: assert property (p_fixed_bits)
    else $error("a bit outside the peripheral positions moved");

  property p_reset_value;
    @(posedge clk) (!rst_n) |=> (guard == pwp_pkg::GUARD_RESET
                                 && reg_rdata == 32'h0000_0000);
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("state after reset is wrong");

  property p_analog_readback;
    @(posedge clk) disable iff (!rst_n)
      (ce && reg_rd && !reg_wr && reg_addr == pwp_pkg::OFF_PROTECT_SET)
      |=> (reg_rdata[19:16] == $past(guard[19:16])
           && reg_rdata[1] == $past(guard[1]) && !reg_rdata[0]);
  endproperty
  a_analog_readback: assert property (p_analog_readback)
    else $error("event router or analog bits read back wrong");

  property p_clear_one;
    @(posedge clk) disable iff (!rst_n)
      (ce && reg_wr && reg_addr == pwp_pkg::OFF_PROTECT_CLEAR)
      |=> ((guard & $past(reg_wdata) & pwp_pkg::GUARD_WRITABLE) == 32'h0
           && (guard & ~$past(reg_wdata))
              == ($past(guard) & ~$past(reg_wdata)));
  endproperty
  a_clear_one: assert property (p_clear_one)
    else $error("clear write did not act on exactly the ones");

  property p_ce_freeze;
    @(posedge clk) disable iff (!rst_n)
      (!ce) |=> ($stable(guard) && $stable(reg_rdata));
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("state moved while clock enable low");

  property p_event_router_set;
    @(posedge clk) disable iff (!rst_n)
      (ce && reg_wr && reg_addr == pwp_pkg::OFF_PROTECT_SET
       && reg_wdata[pwp_pkg::POS_EVENT_ROUTER])
      |=> guard[pwp_pkg::POS_EVENT_ROUTER];
  endproperty
  a_event_router_set: assert property (p_event_router_set)
    else $error("event router bit did not protect");

  property p_serial_set;
    @(posedge clk) disable iff (!rst_n)
      (ce && reg_wr && reg_addr == pwp_pkg::OFF_PROTECT_SET)
      |=> ((guard[SER_HI:SER_LO] & $past(reg_wdata[SER_HI:SER_LO]))
           == $past(reg_wdata[SER_HI:SER_LO]));
  endproperty
  a_serial_set: assert property (p_serial_set)
    else $error("serial unit bit did not protect");

  property p_timer_clear;
    @(posedge clk) disable iff (!rst_n)
      (ce && reg_wr && reg_addr == pwp_pkg::OFF_PROTECT_CLEAR)
      |=> ((guard[TMR_HI:TMR_LO] & $past(reg_wdata[TMR_HI:TMR_LO])) == 8'h00);
  endproperty
  a_timer_clear: assert property (p_timer_clear)
    else $error("timer bit did not unprotect");

  property p_analog_set;
    @(posedge clk) disable iff (!rst_n)
      (ce && reg_wr && reg_addr == pwp_pkg::OFF_PROTECT_SET)
      |=> ((guard[ANA_HI:ANA_LO] & $past(reg_wdata[ANA_HI:ANA_LO]))
           == $past(reg_wdata[ANA_HI:ANA_LO]));
  endproperty
  a_analog_set: assert property (p_analog_set)
    else $error("analog or touch bit did not protect");

  property p_full_readback;
    @(posedge clk) disable iff (!rst_n)
      (ce && reg_rd && (reg_addr == pwp_pkg::OFF_PROTECT_SET
                        || reg_addr == pwp_pkg::OFF_PROTECT_CLEAR))
      |=> (reg_rdata == $past(guard));
  endproperty
  a_full_readback: assert property (p_full_readback)
    else $error("read data differs from protection state");

  property p_fixed_readback;
    @(posedge clk) disable iff (!rst_n)
      (ce && reg_rd && reg_addr == pwp_pkg::OFF_PROTECT_SET)
      |=> ((reg_rdata & ~pwp_pkg::GUARD_WRITABLE)
           == (pwp_pkg::GUARD_RESET & ~pwp_pkg::GUARD_WRITABLE));
  endproperty
  a_fixed_readback: assert property (p_fixed_readback)
    else $error("fixed bits read back wrong");

  property p_event_router_clear;
    @(posedge clk) disable iff (!rst_n)
      (ce && reg_wr && reg_addr == pwp_pkg::OFF_PROTECT_CLEAR
       && reg_wdata[pwp_pkg::POS_EVENT_ROUTER])
      |=> !guard[pwp_pkg::POS_EVENT_ROUTER];
  endproperty
  a_event_router_clear: assert property (p_event_router_clear)
    else $error("event router bit did not unprotect");
endmodule
`default_nettype wire

// ---- pwp_bank_bench.sv ----
// Self-checking bench for the write-protect bank
`timescale 1ns/1ps
`default_nettype none
module pwp_bank_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata;
  logic        reg_err;
  logic [31:0] guard;
  logic [31:0] exp_g;
  int          err_total = 0;
  int          samples_checked = 0;

  always #5 clk = ~clk;

  pwp_bank DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_err(reg_err), .guard(guard));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  // One access: strobe for one cycle, outputs settled at next fall
  task automatic acc(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(negedge clk);
    reg_wr = wr;
    reg_rd = ~wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask

  task automatic give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    exp_g = 32'h0080_0000;
    acc(1'b0, pwp_pkg::OFF_PROTECT_SET, 32'h0000_0000);
    check(reg_rdata, 32'h0080_0000);
    check(guard, exp_g);
    $display("test reset done");
  endtask

  task automatic t_bits;
    for (int i = 1; i < 20; i++) begin
      acc(1'b1, pwp_pkg::OFF_PROTECT_SET, 32'h0000_0001 << i);
      exp_g = exp_g | (32'h0000_0001 << i);
      check(guard, exp_g);
    end
    acc(1'b1, pwp_pkg::OFF_PROTECT_SET, 32'h0000_0000);
    check(guard, exp_g);
    acc(1'b0, pwp_pkg::OFF_PROTECT_CLEAR, 32'h0000_0000);
    check(reg_rdata, 32'h008F_FFFE);
    acc(1'b0, pwp_pkg::OFF_PROTECT_SET, 32'h0000_0000);
    check(reg_rdata, 32'h008F_FFFE);
    acc(1'b1, pwp_pkg::OFF_PROTECT_CLEAR, 32'h0000_0000);
    check(guard, exp_g);
    for (int i = 1; i < 20; i++) begin
      acc(1'b1, pwp_pkg::OFF_PROTECT_CLEAR, 32'h0000_0001 << i);
      exp_g = exp_g & ~(32'h0000_0001 << i);
      check(guard, exp_g);
    end
    $display("test bits done");
  endtask

  task automatic t_refuse;
    acc(1'b1, 8'h08, 32'hFFFF_FFFF);
    check({31'h0, reg_err}, 32'h0000_0001);
    check(reg_rdata, 32'h0000_0000);
    check(guard, exp_g);
    acc(1'b1, pwp_pkg::OFF_PROTECT_SET, 32'hFF70_0001);
    check(guard, exp_g);
    @(negedge clk);
    ce = 1'b0;
    acc(1'b1, pwp_pkg::OFF_PROTECT_SET, 32'h0000_0F00);
    check(guard, exp_g);
    ce = 1'b1;
    acc(1'b1, pwp_pkg::OFF_PROTECT_SET, 32'h0000_0F00);
    check(guard, exp_g | 32'h0000_0F00);
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    check(guard, 32'h0080_0000);
    check(reg_rdata, 32'h0000_0000);
    $display("test refuse done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_bits();
    t_refuse();
    give_verdict();
  end

  // About 47 accesses of 20 ns each; generous margin
  initial begin
    #20000;
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
